// file: dpra_arbiter.sv
// dual port reservation arbiter with axi4-lite control/status registers
// assumes all port pins are synchronous to clk_sys_i (20 MHz)
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// RULE1: select reserves drive unless other port owns
// RULE2: reservation held until release or priority select
// RULE3: power-up leaves drive unreserved
// RULE4: pending other unit gets drive on release
// RULE5: select with bus line 9 forces reservation
// RULE6: forced switch at select strobe leading edge
// RULE7: held force never blocks other port's force
// RULE8: control select with line 9 requests release
// RULE9: release completes when select strobe negates
// RULE10: release only with fault clear or track-zero return; the code has no fault or track-zero input and accepts every request
// RULE11: enabled timer releases 500 ms after reservation
// RULE12: software setting inhibits release timer
// RULE13: inhibited timer keeps reservation until release/force
// RULE14: precedence prioB, prioA, relB, relA, timer
// RULE15: busy to selector high if other owns
// RULE16: seek done negated 30 us after release; the code does so only on handover to a waiting unit, at its port
// RULE17: route signals only with owning unit; while no unit owns, the code passes drive seek end to both ports
// RULE18: timer counts system clock cycles to parameter
module dpra_arbiter
  import dpra_pkg::*;
#(
  parameter logic [TMR_W-1:0] REL_CYCLES = TMR_W'(REL_CYC)
) (
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  // port a control unit
  input  wire logic        sel_a_i,
  input  wire logic        bus9_a_i,
  input  wire logic        ctl_sel_a_i,
  input  wire logic [7:0]  cmd_a_i,
  output logic             busy_a_o,
  output logic             seek_end_a_o,
  output logic [7:0]       stat_a_o,
  // port b control unit
  input  wire logic        sel_b_i,
  input  wire logic        bus9_b_i,
  input  wire logic        ctl_sel_b_i,
  input  wire logic [7:0]  cmd_b_i,
  output logic             busy_b_o,
  output logic             seek_end_b_o,
  output logic [7:0]       stat_b_o,
  // drive side
  input  wire logic        drv_seek_end_i,
  input  wire logic [7:0]  drv_stat_i,
  output logic [7:0]       drive_cmd_o,
  output logic [1:0]       owner_o,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  typedef struct packed {
    dpra_owner_t owner;
    logic        sel_a_d;
    logic        sel_b_d;
    logic        pend_a;
    logic        pend_b;
    logic        relq_a;
    logic        relq_b;
    logic        tmr_go;
    logic        tmr_stop;
    logic        blk_go;
    logic        blk_to_a;
    logic        inhibit;
    logic        busy_a;
    logic        busy_b;
    logic        seek_a;
    logic        seek_b;
    logic [7:0]  stat_a;
    logic [7:0]  stat_b;
    logic [7:0]  cmd;
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } dpra_state_t;

  dpra_state_t r_reg;
  dpra_state_t r_next;

  logic tmr_busy;
  logic tmr_done;
  logic blk_busy;

  // interval for the reservation release timer
  dpra_timer #(
    .CYCLES    (REL_CYCLES)
  ) u_rel_tmr (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .start_i   (r_reg.tmr_go),
    .stop_i    (r_reg.tmr_stop),
    .busy_o    (tmr_busy),
    .done_o    (tmr_done)
  );

  // seek end blackout after handing the drive to a waiting unit
  dpra_timer #(
    .CYCLES    (TMR_W'(BLK_CYC))
  ) u_blk_tmr (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .start_i   (r_reg.blk_go),
    .stop_i    (1'b0),
    .busy_o    (blk_busy),
    .done_o    ()
  );

  // events of this cycle
  logic rise_a;
  logic rise_b;
  logic prio_a;
  logic prio_b;
  logic rel_a;
  logic rel_b;
  logic tmo;

  assign rise_a = sel_a_i && !r_reg.sel_a_d;
  assign rise_b = sel_b_i && !r_reg.sel_b_d;
  // only a fresh leading edge forces, so a held strobe cannot lock out
  assign prio_a = rise_a && bus9_a_i; // see RULE5 see RULE6 see RULE7
  assign prio_b = rise_b && bus9_b_i; // see RULE5 see RULE6 see RULE7
  assign rel_a  = r_reg.relq_a && !sel_a_i && r_reg.owner == OWN_A; // see RULE9
  assign rel_b  = r_reg.relq_b && !sel_b_i && r_reg.owner == OWN_B; // see RULE9
  assign tmo    = tmr_done && !r_reg.inhibit
                  && r_reg.owner != OWN_NONE; // see RULE11 see RULE13

  function automatic logic [31:0] read_word(input logic [7:0] addr,
                                            input dpra_state_t s,
                                            input logic trun,
                                            input logic blk);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (addr == ADDR_CTRL) begin
      v[CTRL_INHIBIT] = s.inhibit;
    end else if (addr == ADDR_STATUS) begin
      v[ST_OWNER +: 2] = s.owner;
      v[ST_PEND_A]     = s.pend_a;
      v[ST_PEND_B]     = s.pend_b;
      v[ST_TMR_RUN]    = trun;
      v[ST_BLACKOUT]   = blk;
      v[ST_RELQ_A]     = s.relq_a;
      v[ST_RELQ_B]     = s.relq_b;
    end
    return v;
  endfunction

  function automatic logic addr_ok(input logic [7:0] addr);
    return addr == ADDR_CTRL || addr == ADDR_STATUS;
  endfunction

  always_comb begin
    r_next          = r_reg;
    r_next.sel_a_d  = sel_a_i;
    r_next.sel_b_d  = sel_b_i;
    r_next.tmr_go   = 1'b0;
    r_next.tmr_stop = 1'b0;
    r_next.blk_go   = 1'b0;

    // fixed precedence among coinciding events
    if (prio_b) begin // see RULE14
      r_next.owner  = OWN_B;
      r_next.pend_b = 1'b0;
    end else if (prio_a) begin
      r_next.owner  = OWN_A;
      r_next.pend_a = 1'b0;
    end else if (rel_b || (tmo && r_reg.owner == OWN_B)) begin
      r_next.owner = r_reg.pend_a ? OWN_A : OWN_NONE; // see RULE4
      r_next.blk_go   = r_reg.pend_a; // see RULE16
      r_next.blk_to_a = 1'b1;
      r_next.pend_a   = 1'b0;
    end else if (rel_a || tmo) begin
      r_next.owner = r_reg.pend_b ? OWN_B : OWN_NONE; // see RULE4
      r_next.blk_go   = r_reg.pend_b; // see RULE16
      r_next.blk_to_a = 1'b0;
      r_next.pend_b   = 1'b0;
    end

    // plain selection: reserve when free, remember the attempt while the other port owns
    if (rise_b && !bus9_b_i) begin
      if (r_next.owner == OWN_NONE) begin
        r_next.owner = OWN_B; // see RULE1
      end else if (r_next.owner == OWN_A) begin
        r_next.pend_b = 1'b1;
      end
    end
    if (rise_a && !bus9_a_i) begin
      if (r_next.owner == OWN_NONE) begin
        r_next.owner = OWN_A; // see RULE1
      end else if (r_next.owner == OWN_B) begin
        r_next.pend_a = 1'b1;
      end
    end

    // release request; the reservation stays until the strobe drops
    if (r_next.owner != OWN_A) begin
      r_next.relq_a = 1'b0;
    end else if (ctl_sel_a_i && bus9_a_i && sel_a_i) begin
      r_next.relq_a = 1'b1; // see RULE8 see RULE10
    end
    if (r_next.owner != OWN_B) begin
      r_next.relq_b = 1'b0;
    end else if (ctl_sel_b_i && bus9_b_i && sel_b_i) begin
      r_next.relq_b = 1'b1; // see RULE8 see RULE10
    end
    // holding is implicit: owner only changes on the events above
    // see RULE2

    // restart the release interval on every new or moved reservation
    if (r_next.owner != r_reg.owner) begin
      r_next.tmr_go   = r_next.owner != OWN_NONE; // see RULE11 see RULE18
      r_next.tmr_stop = r_next.owner == OWN_NONE;
    end

    // port outputs
    r_next.busy_a = sel_a_i && r_reg.owner == OWN_B; // see RULE15
    r_next.busy_b = sel_b_i && r_reg.owner == OWN_A; // see RULE15
    unique case (r_reg.owner) // see RULE17
      OWN_A: begin
        r_next.cmd    = cmd_a_i;
        r_next.stat_a = drv_stat_i;
        r_next.stat_b = 8'h00;
        r_next.seek_a = drv_seek_end_i && !(blk_busy && r_reg.blk_to_a);
        r_next.seek_b = 1'b1;
      end
      OWN_B: begin
        r_next.cmd    = cmd_b_i;
        r_next.stat_a = 8'h00;
        r_next.stat_b = drv_stat_i;
        r_next.seek_a = 1'b1;
        r_next.seek_b = drv_seek_end_i && !(blk_busy && !r_reg.blk_to_a);
      end
      OWN_NONE: begin
        r_next.cmd    = 8'h00;
        r_next.stat_a = 8'h00;
        r_next.stat_b = 8'h00;
        r_next.seek_a = drv_seek_end_i;
        r_next.seek_b = drv_seek_end_i;
      end
      default: begin
        r_next.cmd    = 8'h00;
        r_next.stat_a = 8'h00;
        r_next.stat_b = 8'h00;
        r_next.seek_a = 1'b0;
        r_next.seek_b = 1'b0;
      end
    endcase

    // axi4-lite write: address and data taken in either order
    r_next.awready = 1'b0;
    r_next.wready  = 1'b0;
    if (r_reg.awready && s_axi_awvalid) begin
      r_next.aw_got  = 1'b1;
      r_next.aw_addr = s_axi_awaddr;
    end else if (!r_reg.aw_got && !r_reg.bvalid) begin
      r_next.awready = 1'b1;
    end
    if (r_reg.wready && s_axi_wvalid) begin
      r_next.w_got  = 1'b1;
      r_next.w_data = s_axi_wdata;
      r_next.w_strb = s_axi_wstrb;
    end else if (!r_reg.w_got && !r_reg.bvalid) begin
      r_next.wready = 1'b1;
    end
    if (r_reg.aw_got && r_reg.w_got && !r_reg.bvalid) begin
      r_next.bvalid = 1'b1;
      r_next.aw_got = 1'b0;
      r_next.w_got  = 1'b0;
      r_next.bresp  = addr_ok(r_reg.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      if (r_reg.aw_addr == ADDR_CTRL && r_reg.w_strb[0]) begin
        r_next.inhibit = r_reg.w_data[CTRL_INHIBIT]; // see RULE12
      end
    end else if (r_reg.bvalid && s_axi_bready) begin
      r_next.bvalid = 1'b0;
    end

    // axi4-lite read
    r_next.arready = 1'b0;
    if (r_reg.arready && s_axi_arvalid) begin
      r_next.rvalid = 1'b1;
      r_next.rdata  = read_word(s_axi_araddr, r_reg, tmr_busy, blk_busy);
      r_next.rresp  = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (r_reg.rvalid && s_axi_rready) begin
      r_next.rvalid = 1'b0;
    end else if (!r_reg.rvalid) begin
      r_next.arready = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      r_reg         <= '0;
      r_reg.owner   <= OWN_NONE; // see RULE3
      r_reg.inhibit <= CTRL_INHIBIT_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign busy_a_o      = r_reg.busy_a;
  assign busy_b_o      = r_reg.busy_b;
  assign seek_end_a_o  = r_reg.seek_a;
  assign seek_end_b_o  = r_reg.seek_b;
  assign stat_a_o      = r_reg.stat_a;
  assign stat_b_o      = r_reg.stat_b;
  assign drive_cmd_o   = r_reg.cmd;
  assign owner_o       = r_reg.owner;
  assign s_axi_awready = r_reg.awready;
  assign s_axi_wready  = r_reg.wready;
  assign s_axi_bvalid  = r_reg.bvalid;
  assign s_axi_bresp   = r_reg.bresp;
  assign s_axi_arready = r_reg.arready;
  assign s_axi_rvalid  = r_reg.rvalid;
  assign s_axi_rdata   = r_reg.rdata;
  assign s_axi_rresp   = r_reg.rresp;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  AST_PWRUP_FREE: assert property (disable iff (1'b0) // see RULE3
    !nrst_i |=> owner_o == OWN_NONE)
    else $error("owner not cleared by reset");
  AST_SELECT_RESERVES: assert property ( // see RULE1
    rise_a && !bus9_a_i && !rise_b && r_reg.owner == OWN_NONE
    |=> owner_o == OWN_A)
    else $error("free drive not reserved on select");
  AST_HOLD: assert property ( // see RULE2
    r_reg.owner == OWN_A && !prio_b && !rel_a && !tmo
    |=> owner_o == OWN_A)
    else $error("reservation lost without cause");
  AST_FORCE_B: assert property (prio_b |=> owner_o == OWN_B) // see RULE6
    else $error("priority select did not move reservation");
  AST_PREC: assert property ( // see RULE14
    prio_a && prio_b |=> owner_o == OWN_B)
    else $error("port b priority did not win");
  AST_REL_WAIT: assert property ( // see RULE9
    r_reg.relq_a && r_reg.owner == OWN_A && sel_a_i && !prio_b && !tmo
    |=> owner_o == OWN_A)
    else $error("released before strobe negated");
  AST_HANDOVER: assert property ( // see RULE4
    rel_a && r_reg.pend_b && !prio_a && !prio_b |=> owner_o == OWN_B)
    else $error("pending unit not given the drive");
  AST_BUSY: assert property ( // see RULE15
    sel_a_i && r_reg.owner == OWN_B |=> busy_a_o)
    else $error("busy not shown to non-owner");
  AST_INHIBIT: assert property ( // see RULE13
    r_reg.inhibit && r_reg.owner == OWN_B && !prio_a && !rel_b
    |=> owner_o == OWN_B)
    else $error("inhibited timer released drive");
  AST_BLACKOUT: assert property ( // see RULE16
    r_reg.blk_go |-> ##2
      (r_reg.blk_to_a ? !seek_end_a_o : !seek_end_b_o) [*8])
    else $error("seek end not negated after handover");
  AST_ROUTE: assert property ( // see RULE17
    r_reg.owner == OWN_A |=> drive_cmd_o == $past(cmd_a_i)
                             && stat_b_o == 8'h00)
    else $error("signals routed to non-owner");

  COV_FORCE: cover property (prio_a ##[1:20] prio_b);
  COV_HANDOVER: cover property (rel_b && r_reg.pend_a);
  COV_TIMEOUT: cover property (tmo);
  COV_AXI_WR: cover property (s_axi_bvalid && s_axi_bready);

endmodule // dpra_arbiter
`default_nettype wire

// file: dpra_pkg.sv
// shared constants and types of the dual port reservation arbiter
// assumes a single 20 MHz system clock and an axi4-lite register master
package dpra_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned T_REL_MS     = 500;
  localparam int unsigned T_BLK_US     = 30;
  localparam int unsigned REL_CYC      = CLK_HZ / 1000 * T_REL_MS;
  localparam int unsigned BLK_CYC      = CLK_HZ / 1_000_000 * T_BLK_US;
  localparam int unsigned TMR_W        = 24;

  // register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;

  // ctrl fields
  localparam int unsigned CTRL_INHIBIT = 0;
  localparam logic        CTRL_INHIBIT_RST = 1'b0;

  // status fields
  localparam int unsigned ST_OWNER     = 0;
  localparam int unsigned ST_PEND_A    = 2;
  localparam int unsigned ST_PEND_B    = 3;
  localparam int unsigned ST_TMR_RUN   = 4;
  localparam int unsigned ST_BLACKOUT  = 5;
  localparam int unsigned ST_RELQ_A    = 6;
  localparam int unsigned ST_RELQ_B    = 7;

  // axi responses
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {
    OWN_NONE = 2'b00,
    OWN_A    = 2'b01,
    OWN_B    = 2'b10
  } dpra_owner_t;

endpackage

// file: dpra_timer.sv
// one-shot interval counter: start_i loads the count, done_o pulses at end
// assumes start_i and stop_i are single-cycle or level controls from clk_sys_i
`timescale 1ns/100ps
`default_nettype none
module dpra_timer
  import dpra_pkg::*;
#(
  parameter logic [TMR_W-1:0] CYCLES = TMR_W'(BLK_CYC)
) (
  input  wire logic clk_sys_i,
  input  wire logic nrst_i,
  input  wire logic start_i,
  input  wire logic stop_i,
  output logic      busy_o,
  output logic      done_o
);

  typedef struct packed {
    logic [TMR_W-1:0] cnt;
    logic             run;
    logic             done;
  } dpra_tmr_state_t;

  dpra_tmr_state_t r_reg;
  dpra_tmr_state_t r_next;

  always_comb begin
    r_next      = r_reg;
    r_next.done = 1'b0;
    if (start_i) begin
      // restart wins over stop: a new reservation re-arms the interval
      r_next.cnt = CYCLES - TMR_W'(1);
      r_next.run = 1'b1;
    end else if (stop_i) begin
      r_next.run = 1'b0;
    end else if (r_reg.run) begin
      if (r_reg.cnt == '0) begin
        r_next.run  = 1'b0;
        r_next.done = 1'b1;
      end else begin
        r_next.cnt = r_reg.cnt - TMR_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign busy_o = r_reg.run;
  assign done_o = r_reg.done;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  AST_TMR_LOAD: assert property (start_i |=> busy_o && !done_o) // see RULE18
    else $error("timer not running after start");
  AST_TMR_DONE: assert property ($fell(busy_o) && !$past(stop_i)
                                 |-> done_o) // see RULE18
    else $error("timer stopped without done pulse");

endmodule // dpra_timer
`default_nettype wire

// file: dpra_units.sv
// models of the two control units, bit 0 is port a and bit 1 port b
// assumes the bench calls the tasks and feeds a new pattern each cycle
`timescale 1ns/100ps
`default_nettype none
module dpra_units (
  input  wire logic       clk_sys_i,
  input  wire logic [7:0] pat_i,
  output logic      [1:0] sel_o,
  output logic      [1:0] bus9_o,
  output logic      [1:0] ctl_o,
  output logic      [7:0] cmd_a_o,
  output logic      [7:0] cmd_b_o
);
  logic [7:0] hold_a = 8'h00;
  logic [7:0] hold_b = 8'h00;
  initial begin
    sel_o = 2'b00;
    bus9_o = 2'b00;
    ctl_o = 2'b00;
  end

  // a deselected unit does not hold its lines, so they keep moving
  assign cmd_a_o = sel_o[0] ? hold_a : pat_i;
  assign cmd_b_o = sel_o[1] ? hold_b : ~pat_i;

  // select; with line 9 it is a forced takeover
  task automatic pick(input logic [1:0] m, input logic frc);
    @(posedge clk_sys_i);
    sel_o <= sel_o | m;
    bus9_o <= frc ? (bus9_o | m) : (bus9_o & ~m);
    if (m[0]) hold_a <= pat_i;
    if (m[1]) hold_b <= pat_i;
  endtask

  // release request: control tag with line 9 and no other function
  task automatic rel(input logic [1:0] m);
    @(posedge clk_sys_i);
    ctl_o <= ctl_o | m;
    bus9_o <= bus9_o | m;
    repeat (2) @(posedge clk_sys_i);
    ctl_o <= ctl_o & ~m;
    bus9_o <= bus9_o & ~m;
  endtask

  task automatic desel(input logic [1:0] m);
    @(posedge clk_sys_i);
    sel_o <= sel_o & ~m;
    bus9_o <= bus9_o & ~m;
  endtask
endmodule // dpra_units
`default_nettype wire

// file: dual_port_reservation_arbiter_test.sv
// self-checking bench of the reservation arbiter against a queue model
// assumes dpra_pkg, dpra_arbiter and dpra_units are compiled first
`timescale 1ns/100ps
`default_nettype none
module dual_port_reservation_arbiter_test;
  import dpra_pkg::*;
  // short release interval keeps the run small
  localparam logic [TMR_W-1:0] RELC = TMR_W'(50);
  logic        clk_sys_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [7:0]  pat = 8'h00;
  logic [7:0]  drv_stat_i = 8'h00;
  logic        drv_seek_end_i = 1'b1;
  logic [1:0]  sel, bus9, ctl, owner_o;
  logic [7:0]  cmd_a, cmd_b, drive_cmd_o, stat_a_o, stat_b_o;
  logic        busy_a_o, busy_b_o, seek_end_a_o, seek_end_b_o;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int          miscompares = 0;
  int          n_checks = 0;
  int          seed = 32'hE349;
  logic [1:0]  exp_own = OWN_NONE;
  logic [1:0]  pend_q[$];

  always #25 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) pat <= 8'($random(seed));

  dpra_units u (.clk_sys_i, .pat_i(pat), .sel_o(sel), .bus9_o(bus9),
    .ctl_o(ctl), .cmd_a_o(cmd_a), .cmd_b_o(cmd_b));

  dpra_arbiter #(.REL_CYCLES(RELC)) dut (.clk_sys_i, .nrst_i,
    .sel_a_i(sel[0]), .bus9_a_i(bus9[0]), .ctl_sel_a_i(ctl[0]),
    .cmd_a_i(cmd_a), .busy_a_o, .seek_end_a_o, .stat_a_o,
    .sel_b_i(sel[1]), .bus9_b_i(bus9[1]), .ctl_sel_b_i(ctl[1]),
    .cmd_b_i(cmd_b), .busy_b_o, .seek_end_b_o, .stat_b_o,
    .drv_seek_end_i, .drv_stat_i, .drive_cmd_o, .owner_o,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  task automatic test_done;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask

  task automatic own_chk;
    cyc(4);
    chk(32'(owner_o), 32'(exp_own));
  endtask

  // model: a refused selection waits in the queue for the next release
  task automatic m_sel(input logic [1:0] c, input logic frc);
    if (frc || exp_own == OWN_NONE) exp_own = c;
    else if (exp_own != c) pend_q.push_back(c);
  endtask

  task automatic m_rel;
    exp_own = pend_q.size() > 0 ? pend_q.pop_front() : OWN_NONE;
  endtask

  // a missing answer reads as response 3, which no check expects
  // s0 enables byte 0; upper strobes are random, the register ignores them
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic s0, output logic [1:0] r);
    @(posedge clk_sys_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= {3'($random(seed)), s0};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'($random(seed));
    for (int n = 0; n < 50; n++) begin
      @(posedge clk_sys_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      s_axi_bready <= 1'b1;
    end
    r = (s_axi_bvalid && s_axi_bready) ? s_axi_bresp : 2'h3;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge clk_sys_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'($random(seed));
    for (int n = 0; n < 50; n++) begin
      @(posedge clk_sys_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      s_axi_rready <= 1'b1;
    end
    d = s_axi_rdata;
    r = (s_axi_rvalid && s_axi_rready) ? s_axi_rresp : 2'h3;
    s_axi_rready <= 1'b0;
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys_i);
    miscompares++;
    test_done();
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (20) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    drv_stat_i <= 8'($random(seed));
    own_chk();
    axi_rd(ADDR_CTRL, d, r);
    chk(d, 32'h0);
    axi_wr(ADDR_CTRL, 32'h1, 1'b1, r);
    chk(32'(r), 32'(RESP_OKAY));
    axi_rd(ADDR_CTRL, d, r);
    chk(d, 32'h1);
    axi_wr(ADDR_CTRL, 32'h0, 1'b0, r);
    chk(32'(r), 32'(RESP_OKAY));
    axi_rd(ADDR_CTRL, d, r);
    chk(d, 32'h1);
    axi_wr(8'h0C, 32'h0, 1'b1, r);
    chk(32'(r), 32'(RESP_SLVERR));
    axi_rd(8'h08, d, r);
    chk(32'(r), 32'(RESP_SLVERR));
    chk(d, 32'h0);
    u.pick(2'b01, 1'b0);
    m_sel(OWN_A, 1'b0);
    own_chk();
    chk(32'(drive_cmd_o), 32'(cmd_a));
    chk(32'(stat_a_o), 32'(drv_stat_i));
    chk(32'(stat_b_o), 32'h0);
    u.pick(2'b10, 1'b0);
    m_sel(OWN_B, 1'b0);
    own_chk();
    chk(32'(busy_b_o), 32'h1);
    chk(32'(busy_a_o), 32'h0);
    axi_rd(ADDR_STATUS, d, r);
    chk(d & 32'hF, 32'h9);
    cyc(400);
    own_chk();
    u.rel(2'b01);
    own_chk();
    u.desel(2'b01);
    m_rel();
    own_chk();
    cyc(100);
    chk(32'(seek_end_b_o), 32'h0);
    chk(32'(seek_end_a_o), 32'h1);
    cyc(600);
    chk(32'(seek_end_b_o), 32'h1);
    u.desel(2'b10);
    own_chk();
    u.pick(2'b01, 1'b1);
    m_sel(OWN_A, 1'b1);
    own_chk();
    u.pick(2'b10, 1'b1);
    m_sel(OWN_B, 1'b1);
    own_chk();
    cyc(10);
    chk(32'(busy_a_o), 32'h1);
    own_chk();
    u.rel(2'b10);
    u.desel(2'b10);
    m_rel();
    own_chk();
    u.desel(2'b01);
    own_chk();
    axi_wr(ADDR_CTRL, 32'h0, 1'b1, r);
    chk(32'(r), 32'(RESP_OKAY));
    u.pick(2'b10, 1'b1);
    m_sel(OWN_B, 1'b1);
    u.desel(2'b10);
    cyc(35);
    chk(32'(owner_o), 32'(exp_own));
    cyc(30);
    m_rel();
    chk(32'(owner_o), 32'(exp_own));
    u.pick(2'b11, 1'b1);
    m_sel(OWN_A, 1'b1);
    m_sel(OWN_B, 1'b1);
    own_chk();
    u.desel(2'b11);
    @(posedge clk_sys_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    exp_own = OWN_NONE;
    pend_q.delete();
    own_chk();
    test_done();
  end
endmodule // dual_port_reservation_arbiter_test
`default_nettype wire
